// File: src/dpm_consts.vh
// constants for the diagnostic and power management capability register group
// assumes a byte-addressed configuration space with 32-bit dword access
//
// Summary of operation
// - diag bit 7 set makes identifier reads return all ones; resets to 0.
// - diag bit 6 is read-only and always reads 1.
// - routing bit picks which compat socket register condition sends status-change interrupts.
// - diag bit 4 set disables delayed-transaction handling.
// - diag bit 3 set raises the retry latency limit from 16 to 64.
// - diag bit 2 picks card-side discard timer: 2^10 set, 2^15 clear.
// - diag bit 1 picks host-side discard timer: 2^10 set, 2^15 clear.
// - diag bit 0 clear enables the newer video-port model; set disables it.
// - diag bits survive every reset except the global reset.
// - diag bits 7 and 4..1 are shared, read in both functions and written only through function 0.
// - capability identifier at A0h is read-only and returns 01h.
// - next pointer at A1h is read-only and returns 00h.
// - capability word at A2h resets to FE12h in both functions.
// - wake support field, bits 15..11, reads 11111b by default.
// - bit 15 is writable, resets to 1; firmware clears it without aux power.
// - bits 14..11 are read-only ones.
// - bit 10 is read-only one, D2 supported.
// - diagnostic register at 93h exists in both functions, resets to 60h.
// - bit 9 is read-only one, D1 supported.
// - bits 2..0 are a read-only version field returning 010b.
`ifndef DPM_CONSTS_VH
`define DPM_CONSTS_VH

// configuration offsets
`define DPM_OFF_IDENT        8'h00
`define DPM_OFF_DIAG         8'h93
`define DPM_OFF_CAP_ID       8'hA0
`define DPM_OFF_CAP_NEXT     8'hA1
`define DPM_OFF_CAP_WORD     8'hA2
`define DPM_DW_HI            7
`define DPM_DW_LO            2

// diagnostic register layout
`define DPM_DIAG_RESET       8'h60
`define DPM_DIAG_SHARED_MASK 8'h9E
`define DPM_DIAG_LOCAL_MASK  8'h21
`define DPM_DIAG_FIXED_ONE   8'h40
`define DPM_DG_ID_MASK       7
`define DPM_DG_CSC_ROUTE     5
`define DPM_DG_DTXN_OFF      4
`define DPM_DG_RETRY_LONG    3
`define DPM_DG_CARD_SEL      2
`define DPM_DG_HOST_SEL      1
`define DPM_DG_VIDEO_OFF     0

// capability header
`define DPM_CAP_ID_VAL       8'h01
`define DPM_CAP_NEXT_VAL     8'h00
`define DPM_CAPW_RESET       16'hFE12
`define DPM_CAPW_FIXED       16'h7E12
`define DPM_CAPW_COLD_WAKE   15

// behaviour constants
`define DPM_REG805_ROUTE     4'h0
`define DPM_RETRY_SHORT      7'h10
`define DPM_RETRY_LONG       7'h40
`define DPM_ALL_ONES         32'hFFFFFFFF
`define DPM_TMR_W            16
`define DPM_DISCARD_SHORT    1024
`define DPM_DISCARD_LONG     32768

`endif

// File: src/dpm_discard_timer.v
// delayed-transaction discard timer with a short and a long length
// assumes start and stop are synchronous single-cycle or level requests
`timescale 1ns/1ps
`include "dpm_consts.vh"

module dpm_discard_timer #(
    parameter SHORT_CLKS = `DPM_DISCARD_SHORT,
    parameter LONG_CLKS  = `DPM_DISCARD_LONG
) (
    input  wire clk,        // system clock
    input  wire arst_n,     // global reset, active low
    input  wire start,      // load and start counting
    input  wire stop,       // abandon the count
    input  wire sel_short,  // 1 selects the short length
    output reg  running,    // count in progress
    output reg  expired     // one-cycle pulse at the end of the count
);

    localparam integer          SHORT_M1   = SHORT_CLKS - 1;
    localparam integer          LONG_M1    = LONG_CLKS - 1;
    localparam [`DPM_TMR_W-1:0] LOAD_SHORT = SHORT_M1[`DPM_TMR_W-1:0];
    localparam [`DPM_TMR_W-1:0] LOAD_LONG  = LONG_M1[`DPM_TMR_W-1:0];

    reg [`DPM_TMR_W-1:0] count;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count   <= {`DPM_TMR_W{1'b0}};
            running <= 1'b0;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (stop) begin
                running <= 1'b0;
            end else if (running) begin
                if (count == {`DPM_TMR_W{1'b0}}) begin
                    running <= 1'b0;
                    expired <= 1'b1;
                end else begin
                    count <= count - 1'b1;
                end
            end else if (start) begin
                count   <= sel_short ? LOAD_SHORT : LOAD_LONG;
                running <= 1'b1;
            end
        end
    end

endmodule // dpm_discard_timer

// File: src/dpm_regs.v
// diagnostic control byte and power management capability header, two functions
// assumes configuration cycles arrive as one-cycle strobes with a dword address
// and byte enables; arst_n is the global reset, the only one these bits obey
`timescale 1ns/1ps
`include "dpm_consts.vh"

module dpm_regs #(
    parameter [15:0] VENDOR_ID     = 16'h1A2B,            // arbitrary value
    parameter [15:0] DEVICE_ID     = 16'h3C4D,            // arbitrary value
    parameter        DISCARD_SHORT = `DPM_DISCARD_SHORT,  // short discard count
    parameter        DISCARD_LONG  = `DPM_DISCARD_LONG    // long discard count
) (
    input  wire        clk,                    // system clock, 50 MHz
    input  wire        arst_n,                 // global reset, active low
    input  wire        cfg_rd,                 // configuration read strobe
    input  wire        cfg_wr,                 // configuration write strobe
    input  wire        cfg_func,               // target function, 0 or 1
    input  wire [7:0]  cfg_addr,               // byte address, dword aligned
    input  wire [3:0]  cfg_be,                 // byte enables
    input  wire [31:0] cfg_wdata,              // write data
    output reg  [31:0] cfg_rdata,              // read data
    output reg         cfg_rvalid,             // read data valid pulse
    input  wire [1:0]  csc_event,              // status-change request per function
    input  wire [1:0]  compat_803_b4,          // compat reg 803 bit 4 per function
    input  wire [7:0]  compat_805_hi,          // compat reg 805 bits 7..4, func1:func0
    output reg  [1:0]  csc_pci_irq,            // status-change interrupt to PCI
    output reg         id_mask_select,         // identifier reads masked
    output reg         delayed_txn_off,        // delayed transactions disabled
    output reg  [6:0]  retry_limit,            // retry latency limit in clocks
    output reg  [1:0]  video_port_model_off,   // newer video model off per function
    output reg  [1:0]  pme_cold_support,       // cold-D3 wake advertised per function
    input  wire        card_dt_start,          // card-side delayed txn queued
    input  wire        card_dt_done,           // card-side delayed txn completed
    output wire        card_dt_running,        // card-side discard timer running
    output wire        card_dt_expired,        // card-side discard pulse
    input  wire        host_dt_start,          // host-side delayed txn queued
    input  wire        host_dt_done,           // host-side delayed txn completed
    output wire        host_dt_running,        // host-side discard timer running
    output wire        host_dt_expired         // host-side discard pulse
);

    ////////////////////////////////////////////////////////////////////////////
    // register state

    reg        id_mask;
    reg        dtxn_off;
    reg        retry_long;
    reg        card_sel;
    reg        host_sel;
    reg [1:0]  csc_route;
    reg [1:0]  video_off;
    reg [1:0]  cold_wake;

    wire [7:0] off_ident = `DPM_OFF_IDENT;
    wire [7:0] off_diag  = `DPM_OFF_DIAG;
    wire [7:0] off_cap   = `DPM_OFF_CAP_ID;
    wire [7:0] off_capw  = `DPM_OFF_CAP_WORD;
    wire [5:0] dw_addr   = cfg_addr[`DPM_DW_HI:`DPM_DW_LO];
    wire [5:0] dw_ident  = off_ident[`DPM_DW_HI:`DPM_DW_LO];
    wire [5:0] dw_diag   = off_diag[`DPM_DW_HI:`DPM_DW_LO];
    wire [5:0] dw_cap    = off_cap[`DPM_DW_HI:`DPM_DW_LO];
    wire [1:0] lane_diag = off_diag[`DPM_DW_LO-1:0];
    wire [1:0] lane_capw = off_capw[`DPM_DW_LO-1:0];

    wire       wr_diag = cfg_wr && (dw_addr == dw_diag) && cfg_be[lane_diag];
    wire       wr_capw = cfg_wr && (dw_addr == dw_cap) && cfg_be[lane_capw + 2'b01];
    wire [7:0] diag_wdata = cfg_wdata[{lane_diag, 3'b000} +: 8];
    wire [7:0] capw_wdata = cfg_wdata[{lane_capw + 2'b01, 3'b000} +: 8];

    ////////////////////////////////////////////////////////////////////////////
    // diagnostic register writes, global reset only

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            id_mask    <= 1'b0;
            dtxn_off   <= 1'b0;
            retry_long <= 1'b0;
            card_sel   <= 1'b0;
            host_sel   <= 1'b0;
            csc_route  <= 2'b11;
            video_off  <= 2'b00;
        end else if (wr_diag) begin
            // shared bits only move on a function 0 access
            if (!cfg_func) begin
                id_mask    <= diag_wdata[`DPM_DG_ID_MASK];
                dtxn_off   <= diag_wdata[`DPM_DG_DTXN_OFF];
                retry_long <= diag_wdata[`DPM_DG_RETRY_LONG];
                card_sel   <= diag_wdata[`DPM_DG_CARD_SEL];
                host_sel   <= diag_wdata[`DPM_DG_HOST_SEL];
            end
            csc_route[cfg_func] <= diag_wdata[`DPM_DG_CSC_ROUTE];
            video_off[cfg_func] <= diag_wdata[`DPM_DG_VIDEO_OFF];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // capability word, only the cold-D3 wake bit is writable

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cold_wake <= 2'b11;
        end else if (wr_capw) begin
            cold_wake[cfg_func] <= capw_wdata[`DPM_CAPW_COLD_WAKE - 8];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path

    reg [7:0]  diag_view;
    reg [15:0] capw_view;
    reg [31:0] next_rdata;

    always @* begin
        diag_view = `DPM_DIAG_FIXED_ONE;
        diag_view[`DPM_DG_ID_MASK]    = id_mask;
        diag_view[`DPM_DG_DTXN_OFF]   = dtxn_off;
        diag_view[`DPM_DG_RETRY_LONG] = retry_long;
        diag_view[`DPM_DG_CARD_SEL]   = card_sel;
        diag_view[`DPM_DG_HOST_SEL]   = host_sel;
        diag_view[`DPM_DG_CSC_ROUTE]  = csc_route[cfg_func];
        diag_view[`DPM_DG_VIDEO_OFF]  = video_off[cfg_func];
        // fixed ones in 14..9 and 4, version 010b, rest zero
        capw_view = `DPM_CAPW_FIXED;
        capw_view[`DPM_CAPW_COLD_WAKE] = cold_wake[cfg_func];
        next_rdata = 32'h00000000;
        if (dw_addr == dw_ident) begin
            if (id_mask) begin
                next_rdata = `DPM_ALL_ONES;
            end else begin
                next_rdata = {DEVICE_ID, VENDOR_ID};
            end
        end else if (dw_addr == dw_diag) begin
            next_rdata[{lane_diag, 3'b000} +: 8] = diag_view;
        end else if (dw_addr == dw_cap) begin
            next_rdata = {capw_view, `DPM_CAP_NEXT_VAL, `DPM_CAP_ID_VAL};
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_rdata  <= 32'h00000000;
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rvalid <= cfg_rd;
            if (cfg_rd) begin
                cfg_rdata <= next_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status-change interrupt routing

    reg [1:0] next_csc_irq;
    integer   f;

    always @* begin
        next_csc_irq = 2'b00;
        for (f = 0; f < 2; f = f + 1) begin
            if (csc_route[f]) begin
                // 803 bit 4 is a don't care in this mode
                next_csc_irq[f] = csc_event[f] &&
                    (compat_805_hi[f*4 +: 4] == `DPM_REG805_ROUTE);
            end else begin
                next_csc_irq[f] = csc_event[f] && compat_803_b4[f];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control outputs

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            csc_pci_irq          <= 2'b00;
            id_mask_select       <= 1'b0;
            delayed_txn_off      <= 1'b0;
            retry_limit          <= `DPM_RETRY_SHORT;
            video_port_model_off <= 2'b00;
            pme_cold_support     <= 2'b11;
        end else begin
            csc_pci_irq          <= next_csc_irq;
            id_mask_select       <= id_mask;
            delayed_txn_off      <= dtxn_off;
            retry_limit          <= retry_long ? `DPM_RETRY_LONG
                                               : `DPM_RETRY_SHORT;
            video_port_model_off <= video_off;
            pme_cold_support     <= cold_wake;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // discard timers, held idle while delayed transactions are off

    dpm_discard_timer #(
        .SHORT_CLKS (DISCARD_SHORT),
        .LONG_CLKS  (DISCARD_LONG)
    ) u_card_timer (
        .clk       (clk),
        .arst_n    (arst_n),
        .start     (card_dt_start && !dtxn_off),
        .stop      (card_dt_done || dtxn_off),
        .sel_short (card_sel),
        .running   (card_dt_running),
        .expired   (card_dt_expired)
    );

    dpm_discard_timer #(
        .SHORT_CLKS (DISCARD_SHORT),
        .LONG_CLKS  (DISCARD_LONG)
    ) u_host_timer (
        .clk       (clk),
        .arst_n    (arst_n),
        .start     (host_dt_start && !dtxn_off),
        .stop      (host_dt_done || dtxn_off),
        .sel_short (host_sel),
        .running   (host_dt_running),
        .expired   (host_dt_expired)
    );

endmodule // dpm_regs

// File: bench/dpm_regs_assertions.sv
// concurrent checks on the ports of the register group
// assumes binding to dpm_regs, one clock domain
`timescale 1ns/1ps
module dpm_regs_assertions #(
    parameter [15:0] VENDOR_ID = 16'h1A2B, // arbitrary value
    parameter [15:0] DEVICE_ID = 16'h3C4D  // arbitrary value
) (
    input wire        clk,                  // clock
    input wire        arst_n,               // global reset
    input wire        cfg_rd,               // read strobe
    input wire        cfg_func,             // function
    input wire [7:0]  cfg_addr,             // address
    input wire [31:0] cfg_rdata,            // read data
    input wire        cfg_rvalid,           // read valid
    input wire [1:0]  csc_event,            // status change in
    input wire [1:0]  csc_pci_irq,          // status change out
    input wire        id_mask_select,       // id masking
    input wire        delayed_txn_off,      // delayed txn off
    input wire [6:0]  retry_limit,          // retry limit
    input wire [1:0]  video_port_model_off, // video model off
    input wire [1:0]  pme_cold_support,     // cold wake
    input wire        card_dt_running,      // card timer running
    input wire        card_dt_expired       // card timer pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire rd_id = cfg_rd && (cfg_addr[7:2] == 6'h00);
    wire rd_dg = cfg_rd && (cfg_addr[7:2] == 6'h24);
    wire rd_cp = cfg_rd && (cfg_addr[7:2] == 6'h28);
    ////////////////////////////////////////////////////////////////////////////
    // registered control outputs one cycle after the read equal the bits the read saw
    id_read_a: assert property (rd_id |=> cfg_rdata == (id_mask_select ?
        32'hFFFFFFFF : {DEVICE_ID, VENDOR_ID})) else $error("identifier read wrong");
    rvalid_cause_a: assert property (cfg_rvalid |-> $past(cfg_rd))
        else $error("read valid without read");
    diag_fixed_a: assert property (rd_dg |=> cfg_rdata[30]
        && cfg_rdata[23:0] == 24'h000000) else $error("diag fixed bits wrong");
    diag_bits_a: assert property (rd_dg |=> cfg_rdata[31] == id_mask_select
        && cfg_rdata[28] == delayed_txn_off && cfg_rdata[27] == (retry_limit == 7'h40)
        && cfg_rdata[24] == video_port_model_off[$past(cfg_func)]) else $error("diag bits wrong");
    cap_fixed_a: assert property (rd_cp |=>
        cfg_rdata[30:0] == 31'h7E120001) else $error("capability header wrong");
    cold_wake_a: assert property (rd_cp |=>
        cfg_rdata[31] == pme_cold_support[$past(cfg_func)]) else $error("cold wake bit wrong");
    csc_quiet_a: assert property (csc_event == 2'b00 |=> csc_pci_irq == 2'b00)
        else $error("status interrupt without event");
    dtxn_stop_a: assert property (delayed_txn_off [*2] |-> !card_dt_running)
        else $error("timer runs while disabled");
    expire_end_a: assert property (card_dt_expired |-> !card_dt_running && $past(card_dt_running))
        else $error("expiry not at end of count");
    cover property (card_dt_expired);
    cover property (rd_id && id_mask_select);
    cover property (csc_pci_irq[0]);
endmodule // dpm_regs_assertions
bind dpm_regs dpm_regs_assertions #(.VENDOR_ID(VENDOR_ID), .DEVICE_ID(DEVICE_ID))
    i_dpm_regs_assertions (.clk(clk), .arst_n(arst_n), .cfg_rd(cfg_rd), .cfg_func(cfg_func),
    .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .csc_event(csc_event),
    .csc_pci_irq(csc_pci_irq), .id_mask_select(id_mask_select), .delayed_txn_off(delayed_txn_off),
    .retry_limit(retry_limit), .video_port_model_off(video_port_model_off),
    .pme_cold_support(pme_cold_support), .card_dt_running(card_dt_running),
    .card_dt_expired(card_dt_expired));

// File: bench/dpm_host_model.sv
// host configuration software model: one-cycle read and write strobes
// assumes the bench calls its tasks from one process
`timescale 1ns/1ps
module dpm_host_model (
    input  wire        clk,        // clock
    input  wire        cfg_rvalid, // read valid
    input  wire [31:0] cfg_rdata,  // read data
    output reg         cfg_rd,     // read strobe
    output reg         cfg_wr,     // write strobe
    output reg         cfg_func,   // function
    output reg  [7:0]  cfg_addr,   // address
    output reg  [3:0]  cfg_be,     // byte enables
    output reg  [31:0] cfg_wdata   // write data
);
    initial begin
        {cfg_rd, cfg_wr, cfg_func, cfg_addr, cfg_be, cfg_wdata} = 47'h0;
    end
    // released address and write data lines show the inverse of the last value; function and byte enables hold
    task wr(input reg f, input reg [7:0] a, input reg [3:0] be, input reg [31:0] d);
        begin
            @(posedge clk);
            {cfg_wr, cfg_func, cfg_addr, cfg_be, cfg_wdata} <= {1'b1, f, a, be, d};
            @(posedge clk);
            {cfg_wr, cfg_addr, cfg_wdata} <= {1'b0, ~a, ~d};
        end
    endtask
    task rd(input reg f, input reg [7:0] a, output reg [31:0] d);
        begin
            @(posedge clk);
            {cfg_rd, cfg_func, cfg_addr} <= {1'b1, f, a};
            @(posedge clk);
            {cfg_rd, cfg_addr} <= {1'b0, ~a};
            #1;
            d = (cfg_rvalid === 1'b1) ? cfg_rdata : 32'hxxxxxxxx;
        end
    endtask
endmodule // dpm_host_model

// File: bench/tb.sv
// self-checking bench for the diagnostic and capability register group
// assumes shortened discard counts of 8 and 64 clocks
`timescale 1ns/1ps
module tb;
    localparam [15:0] VEN = 16'h1A2B; // arbitrary value
    localparam [15:0] DEV = 16'h3C4D; // arbitrary value
    reg clk, arst_n, card_dt_start, card_dt_done, host_dt_start, host_dt_done;
    reg  [1:0] csc_event, compat_803_b4;
    reg  [7:0] compat_805_hi;
    wire cfg_rd, cfg_wr, cfg_func, cfg_rvalid, id_mask_select, delayed_txn_off;
    wire card_dt_running, card_dt_expired, host_dt_running, host_dt_expired;
    wire [7:0] cfg_addr;
    wire [3:0] cfg_be;
    wire [31:0] cfg_wdata, cfg_rdata;
    wire [1:0] csc_pci_irq, video_port_model_off, pme_cold_support;
    wire [6:0] retry_limit;
    integer failures, checked, cyc, i;
    reg [31:0] d;
    reg [40:0] rows [0:5];
    dpm_regs #(.VENDOR_ID(VEN), .DEVICE_ID(DEV), .DISCARD_SHORT(8), .DISCARD_LONG(64)) i_dpm_regs (
        .clk(clk), .arst_n(arst_n), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_func(cfg_func),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid), .csc_event(csc_event), .compat_803_b4(compat_803_b4),
        .compat_805_hi(compat_805_hi), .csc_pci_irq(csc_pci_irq), .id_mask_select(id_mask_select),
        .delayed_txn_off(delayed_txn_off), .retry_limit(retry_limit),
        .video_port_model_off(video_port_model_off), .pme_cold_support(pme_cold_support),
        .card_dt_start(card_dt_start), .card_dt_done(card_dt_done),
        .card_dt_running(card_dt_running), .card_dt_expired(card_dt_expired),
        .host_dt_start(host_dt_start), .host_dt_done(host_dt_done),
        .host_dt_running(host_dt_running), .host_dt_expired(host_dt_expired));
    dpm_host_model i_dpm_host_model (.clk(clk), .cfg_rvalid(cfg_rvalid), .cfg_rdata(cfg_rdata),
        .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_func(cfg_func), .cfg_addr(cfg_addr),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));
    ////////////////////////////////////////////////////////////////////////////
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task report_and_stop;
        begin
            $display("checked=%0d failures=%0d", checked, failures);
            if (failures == 0 && checked > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask
    task rdchk(input reg f, input reg [7:0] a, input [31:0] exp);
        begin
            i_dpm_host_model.rd(f, a, d);
            chk(d, exp);
        end
    endtask
    task run_rows;
        for (i = 0; i < 6; i = i + 1) begin
            rdchk(rows[i][40], rows[i][39:32], rows[i][31:0]);
        end
    endtask
    task status_change_route_sel(input [1:0] ev, input [1:0] b803, input [7:0] n805, input [1:0] exp);
        begin
            @(posedge clk);
            {csc_event, compat_803_b4, compat_805_hi} <= {ev, b803, n805};
            repeat (2) @(posedge clk);
            #1;
            chk(csc_pci_irq, exp);
        end
    endtask
    task timer(input reg host, input integer exp);
        integer n;
        begin
            @(posedge clk);
            {host_dt_start, card_dt_start} <= {host, !host};
            @(posedge clk);
            {host_dt_start, card_dt_start} <= 2'b00;
            n = 1;
            #1;
            chk(host ? host_dt_running : card_dt_running, exp < 200);
            while ((host ? host_dt_expired : card_dt_expired) !== 1'b1 && n < 200) begin
                @(posedge clk);
                #1;
                n = n + 1;
            end
            chk(n, exp);
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            failures = failures + 1;
            report_and_stop;
        end
    end
    initial begin
        {arst_n, card_dt_start, card_dt_done, host_dt_start, host_dt_done} = 5'h00;
        {csc_event, compat_803_b4, compat_805_hi} = 12'h000;
        {failures, checked, cyc} = 0;
        rows[0] = {1'b0, 8'h00, DEV, VEN};
        rows[1] = {1'b0, 8'h93, 32'h60000000};
        rows[2] = {1'b1, 8'h90, 32'h60000000};
        rows[3] = {1'b0, 8'hA0, 32'hFE120001};
        rows[4] = {1'b1, 8'hA2, 32'hFE120001};
        rows[5] = {1'b0, 8'h40, 32'h00000000};
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        #1;
        chk({retry_limit, pme_cold_support}, {7'h10, 2'b11});
        run_rows;
        i_dpm_host_model.wr(1'b0, 8'h90, 4'h8, 32'hFF000000);
        rdchk(1'b0, 8'h90, 32'hFF000000);
        rdchk(1'b1, 8'h90, 32'hFE000000);
        rdchk(1'b1, 8'h00, 32'hFFFFFFFF);
        chk({id_mask_select, delayed_txn_off, video_port_model_off, retry_limit},
            {1'b1, 1'b1, 2'b01, 7'h40});
        i_dpm_host_model.wr(1'b1, 8'h90, 4'h8, 32'h00000000);
        rdchk(1'b1, 8'h90, 32'hDE000000);
        rdchk(1'b0, 8'h90, 32'hFF000000);
        i_dpm_host_model.wr(1'b0, 8'hA0, 4'hF, 32'h0000FFFE);
        rdchk(1'b0, 8'hA0, 32'h7E120001);
        rdchk(1'b1, 8'hA0, 32'hFE120001);
        chk(pme_cold_support, 2'b10);
        status_change_route_sel(2'b01, 2'b00, 8'h00, 2'b01);
        status_change_route_sel(2'b01, 2'b01, 8'h01, 2'b00);
        i_dpm_host_model.wr(1'b0, 8'h90, 4'h8, 32'h04000000);
        status_change_route_sel(2'b01, 2'b01, 8'hFF, 2'b01);
        status_change_route_sel(2'b11, 2'b10, 8'h00, 2'b10);
        timer(1'b0, 9);
        timer(1'b1, 65);
        @(posedge clk);
        card_dt_start <= 1'b1;
        @(posedge clk);
        {card_dt_start, card_dt_done} <= 2'b01;
        @(posedge clk);
        card_dt_done <= 1'b0;
        #1;
        chk({card_dt_running, card_dt_expired}, 2'b00);
        i_dpm_host_model.wr(1'b0, 8'h90, 4'h8, 32'h10000000);
        timer(1'b0, 200);
        chk(card_dt_running, 1'b0);
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        run_rows;
        chk({delayed_txn_off, retry_limit, pme_cold_support}, {1'b0, 7'h10, 2'b11});
        report_and_stop;
    end
endmodule // tb
